// *** design/segment_lcd_driver_defs.vh ***
`ifndef SEGMENT_LCD_DRIVER_DEFS_VH
`define SEGMENT_LCD_DRIVER_DEFS_VH

// ----------------------------------------
// register addresses and reset values
// ----------------------------------------
`define LCD_DRIVE_VOLTAGE_SELECT_ADDR 8'hFC
`define LCD_DISPLAY_CONTROL_ADDR 8'hFD
`define LCD_DRIVE_VOLTAGE_SELECT_RST 8'h00
`define LCD_DISPLAY_CONTROL_RST 8'h00

// ----------------------------------------
// display memory window
// ----------------------------------------
`define LCD_RAM_PAGE 4'h8
`define LCD_RAM_FIRST 8'h30
`define LCD_RAM_LAST 8'h45
`define LCD_SEG_COUNT 22
`define LCD_COM_COUNT 8
`define LCD_PIN_COUNT 24
`define LCD_SHARED_FIRST 2
`define LCD_SHARED_END 8

// ----------------------------------------
// display control fields
// ----------------------------------------
`define CTRL_ON_BIT 0
`define CTRL_BIAS_TYPE_HI 2
`define CTRL_BIAS_TYPE_LO 1
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 3
`define CTRL_CLK_HI 7
`define CTRL_CLK_LO 6

// duty/bias codes
`define DUTY_8_BIAS_4 3'h0
`define DUTY_4_BIAS_3 3'h1
`define DUTY_3_BIAS_3 3'h2
`define DUTY_2_BIAS_2 3'h3

// last common index and top bias level
`define LAST_COM_8 3'h7
`define LAST_COM_4 3'h3
`define LAST_COM_3 3'h2
`define LAST_COM_2 3'h1
`define BIAS_4 3'h4
`define BIAS_3 3'h3
`define BIAS_2 3'h2

// ----------------------------------------
// frame clock dividers (watch clock edges per step, minus one)
// ----------------------------------------
`define CLK_SEL_128 2'h0
`define CLK_SEL_256 2'h1
`define CLK_SEL_512 2'h2
`define DIV_128 8'hFF
`define DIV_256 8'h7F
`define DIV_512 8'h3F
`define DIV_1024 8'h1F

// ----------------------------------------
// drive levels (index into the bias supply ladder)
// ----------------------------------------
`define LVL_W 3
`define LVL_IDLE 3'h0
`define LVL_COM_UNSEL 3'h1
`define LVL_SEG_ON 3'h0
`define LVL_SEG_OFF 3'h2

`endif

// *** design/segment_lcd_driver.v ***
// Behaviour
// - display memory page 8, 30H..45H, bit/byte access
// - byte per segment, bit k is common k
// - set bit selects, clear bit non-selects
// - columns fetched autonomously on frame clock
// - unused display bytes stay general storage
// - control register resets to zero
// - control write restarts clock and duty sequencing
// - frame clock derived from watch clock
// - selected clock sets common stepping rate
// - scanning needs core clock, watch clock is only sampled
// - 1/8 and 1/4 duty pin assignment
// - 1/3 and 1/2 duty pin assignment
// - control fields: on, duty, clock, bias type
// - mode register selects drive voltage
// - mode register resets to zero
// - watch timer off stops common and polarity stepping
`timescale 1ns/1ps
`include "segment_lcd_driver_defs.vh"

module segment_lcd_driver (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire watch_clock_in,
	input wire watch_timer_en_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire sfr_rd_in,
	input wire [7:0] sfr_wdata_in,
	output wire [7:0] sfr_rdata_out,
	input wire [11:0] ram_addr_in,
	input wire ram_wr_in,
	input wire ram_bit_wr_in,
	input wire [2:0] ram_bit_sel_in,
	input wire ram_bit_val_in,
	input wire ram_rd_in,
	input wire [7:0] ram_wdata_in,
	output wire [7:0] ram_rdata_out,
	output wire [`LCD_PIN_COUNT*`LVL_W-1:0] pin_level_out,
	output wire display_on_out,
	output wire [1:0] bias_type_out,
	output wire [7:0] lcd_drive_voltage_out,
	output wire [2:0] com_phase_out,
	output wire frame_polarity_out
);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	reg [7:0] disp_ctrl_r;
	reg [7:0] drv_volt_r;
	reg [7:0] sfr_rdata_r;
	reg [7:0] sfr_rdata_nxt;
	wire ctrl_wr;
	wire volt_wr;

	assign ctrl_wr = sfr_wr_in && (sfr_addr_in == `LCD_DISPLAY_CONTROL_ADDR);
	assign volt_wr = sfr_wr_in && (sfr_addr_in == `LCD_DRIVE_VOLTAGE_SELECT_ADDR);

	// read mux, unmapped addresses read as zero
	always @* begin
		sfr_rdata_nxt = sfr_rdata_r;
		if (sfr_rd_in) begin
			if (sfr_addr_in == `LCD_DISPLAY_CONTROL_ADDR) begin
				sfr_rdata_nxt = disp_ctrl_r;
			end else if (sfr_addr_in == `LCD_DRIVE_VOLTAGE_SELECT_ADDR) begin
				sfr_rdata_nxt = drv_volt_r;
			end else begin
				sfr_rdata_nxt = 8'h00;
			end
		end
	end

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			disp_ctrl_r <= `LCD_DISPLAY_CONTROL_RST;
			drv_volt_r <= `LCD_DRIVE_VOLTAGE_SELECT_RST;
			sfr_rdata_r <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				disp_ctrl_r <= sfr_wdata_in;
			end
			if (volt_wr) begin
				drv_volt_r <= sfr_wdata_in;
			end
			sfr_rdata_r <= sfr_rdata_nxt;
		end
	end

	// ----------------------------------------
	// control field decode
	// ----------------------------------------
	wire disp_on;
	wire [2:0] duty_sel;
	wire [1:0] clk_sel;

	assign disp_on = disp_ctrl_r[`CTRL_ON_BIT];
	assign duty_sel = disp_ctrl_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
	assign clk_sel = disp_ctrl_r[`CTRL_CLK_HI:`CTRL_CLK_LO];

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	reg [2:0] last_com;
	reg [2:0] bias_top;
	reg [7:0] div_term;

	always @* begin
		case (duty_sel)
			`DUTY_4_BIAS_3: begin
				last_com = `LAST_COM_4;
				bias_top = `BIAS_3;
			end
			`DUTY_3_BIAS_3: begin
				last_com = `LAST_COM_3;
				bias_top = `BIAS_3;
			end
			`DUTY_2_BIAS_2: begin
				last_com = `LAST_COM_2;
				bias_top = `BIAS_2;
			end
			default: begin
				last_com = `LAST_COM_8;
				bias_top = `BIAS_4;
			end
		endcase
	end

	always @* begin
		case (clk_sel)
			`CLK_SEL_128: div_term = `DIV_128;
			`CLK_SEL_256: div_term = `DIV_256;
			`CLK_SEL_512: div_term = `DIV_512;
			default: div_term = `DIV_1024;
		endcase
	end

	// ----------------------------------------
	// display memory
	// ----------------------------------------
	reg [7:0] disp_ram [0:`LCD_SEG_COUNT-1];
	reg [7:0] ram_rdata_r;
	wire ram_hit;
	wire [7:0] ram_off;
	wire [4:0] ram_idx;
	wire [7:0] ram_cur;
	wire [7:0] bit_mask;
	wire [7:0] ram_wr_data;
	wire ram_wr_any;

	assign ram_hit = (ram_addr_in[11:8] == `LCD_RAM_PAGE) &&
		(ram_addr_in[7:0] >= `LCD_RAM_FIRST) && (ram_addr_in[7:0] <= `LCD_RAM_LAST);
	assign ram_off = ram_addr_in[7:0] - `LCD_RAM_FIRST;
	assign ram_idx = ram_off[4:0];
	assign ram_cur = ram_hit ? disp_ram[ram_idx] : 8'h00;
	assign bit_mask = 8'h01 << ram_bit_sel_in;
	// single-bit write merges into the stored byte
	assign ram_wr_data = ram_bit_wr_in ?
		((ram_cur & ~bit_mask) | ({8{ram_bit_val_in}} & bit_mask)) : ram_wdata_in;
	assign ram_wr_any = ram_hit && (ram_wr_in || ram_bit_wr_in);

	genvar gi;
	generate
		for (gi = 0; gi < `LCD_SEG_COUNT; gi = gi + 1) begin : g_ram
			always @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					disp_ram[gi] <= 8'h00;
				end else if (ram_wr_any && (ram_idx == gi)) begin
					disp_ram[gi] <= ram_wr_data;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// display memory read port
	// ----------------------------------------
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ram_rdata_r <= 8'h00;
		end else if (ram_rd_in) begin
			ram_rdata_r <= ram_cur;
		end
	end

	// ----------------------------------------
	// watch clock synchroniser and frame clock divider
	// ----------------------------------------
	reg wclk_s1_r;
	reg wclk_s2_r;
	reg wclk_s3_r;
	reg [7:0] div_cnt_r;
	wire wclk_edge;
	wire frame_step;

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wclk_s1_r <= 1'b0;
			wclk_s2_r <= 1'b0;
			wclk_s3_r <= 1'b0;
		end else begin
			wclk_s1_r <= watch_clock_in;
			wclk_s2_r <= wclk_s1_r;
			wclk_s3_r <= wclk_s2_r;
		end
	end

	// ----------------------------------------
	// frame clock divider
	// ----------------------------------------
	assign wclk_edge = wclk_s2_r && !wclk_s3_r && watch_timer_en_in;
	assign frame_step = wclk_edge && (div_cnt_r >= div_term) && !ctrl_wr;

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_cnt_r <= 8'h00;
		end else if (ctrl_wr) begin
			div_cnt_r <= 8'h00;
		end else if (wclk_edge) begin
			if (div_cnt_r >= div_term) begin
				div_cnt_r <= 8'h00;
			end else begin
				div_cnt_r <= div_cnt_r + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// common sequencer
	// ----------------------------------------
	reg [2:0] com_idx_r;
	reg [2:0] com_idx_nxt;
	reg pol_r;
	reg pol_nxt;

	always @* begin
		com_idx_nxt = com_idx_r;
		pol_nxt = pol_r;
		if (ctrl_wr) begin
			com_idx_nxt = 3'h0;
			pol_nxt = 1'b0;
		end else if (frame_step) begin
			if (com_idx_r >= last_com) begin
				com_idx_nxt = 3'h0;
				// alternate polarity each frame, no dc across glass
				pol_nxt = !pol_r;
			end else begin
				com_idx_nxt = com_idx_r + 3'h1;
			end
		end
	end

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			com_idx_r <= 3'h0;
			pol_r <= 1'b0;
		end else begin
			com_idx_r <= com_idx_nxt;
			pol_r <= pol_nxt;
		end
	end

	// ----------------------------------------
	// column fetch: one bit per segment for the active common
	// ----------------------------------------
	reg [`LCD_SEG_COUNT-1:0] seg_col_r;
	wire fetch;

	// refetch on restart too, so common 0 shows current data
	assign fetch = frame_step || ctrl_wr;

	generate
		for (gi = 0; gi < `LCD_SEG_COUNT; gi = gi + 1) begin : g_col
			always @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					seg_col_r[gi] <= 1'b0;
				end else if (fetch) begin
					seg_col_r[gi] <= disp_ram[gi][com_idx_nxt];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// pin level generation
	// ----------------------------------------
	reg [`LCD_PIN_COUNT*`LVL_W-1:0] pin_level_r;

	generate
		for (gi = 0; gi < `LCD_PIN_COUNT; gi = gi + 1) begin : g_pin
			wire is_com;
			wire com_sel;
			wire seg_bit;
			wire [`LVL_W-1:0] raw_lvl;
			wire [`LVL_W-1:0] drv_lvl;

			// shared pins are commons only while the duty needs them
			if (gi < `LCD_SHARED_FIRST) begin : g_c
				assign is_com = 1'b1;
				assign seg_bit = 1'b0;
			end else if (gi < `LCD_SHARED_END) begin : g_s
				assign is_com = (gi <= last_com);
				assign seg_bit = seg_col_r[gi-`LCD_SHARED_FIRST];
			end else begin : g_g
				assign is_com = 1'b0;
				assign seg_bit = seg_col_r[gi-`LCD_SHARED_FIRST];
			end

			assign com_sel = (com_idx_r == gi);
			assign raw_lvl = is_com ? (com_sel ? bias_top : `LVL_COM_UNSEL) :
				(seg_bit ? `LVL_SEG_ON : `LVL_SEG_OFF);
			assign drv_lvl = pol_r ? (bias_top - raw_lvl) : raw_lvl;

			always @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					pin_level_r[gi*`LVL_W +: `LVL_W] <= `LVL_IDLE;
				end else if (!disp_on) begin
					pin_level_r[gi*`LVL_W +: `LVL_W] <= `LVL_IDLE;
				end else begin
					pin_level_r[gi*`LVL_W +: `LVL_W] <= drv_lvl;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign sfr_rdata_out = sfr_rdata_r;
	assign ram_rdata_out = ram_rdata_r;
	assign pin_level_out = pin_level_r;
	assign display_on_out = disp_ctrl_r[`CTRL_ON_BIT];
	assign bias_type_out = disp_ctrl_r[`CTRL_BIAS_TYPE_HI:`CTRL_BIAS_TYPE_LO];
	assign lcd_drive_voltage_out = drv_volt_r;
	assign com_phase_out = com_idx_r;
	assign frame_polarity_out = pol_r;

endmodule

// *** test/segment_lcd_driver_props.sv ***
`timescale 1ns/1ps
`include "segment_lcd_driver_defs.vh"
module segment_lcd_driver_props (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire watch_timer_en_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire sfr_rd_in,
	input wire [7:0] sfr_wdata_in,
	input wire [7:0] sfr_rdata_out,
	input wire [11:0] ram_addr_in,
	input wire ram_rd_in,
	input wire [7:0] ram_rdata_out,
	input wire [`LCD_PIN_COUNT*`LVL_W-1:0] pin_level_out,
	input wire display_on_out,
	input wire [1:0] bias_type_out,
	input wire [7:0] lcd_drive_voltage_out,
	input wire [2:0] com_phase_out,
	input wire frame_polarity_out
);
	// ----
	// bus and scan checks
	// ----
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire ctrl_wr = sfr_wr_in && sfr_addr_in == 8'hFD;
	wire fc = sfr_addr_in == 8'hFC;
	wire hit = ram_addr_in[11:8] == 4'h8 && ram_addr_in[7:0] >= 8'h30
		&& ram_addr_in[7:0] <= 8'h45;
	a_off_idle: assert property (!display_on_out |=> pin_level_out == 0)
		else $error("pins driven while display off");
	a_ctrl_write: assert property (ctrl_wr |=> display_on_out == $past(sfr_wdata_in[0])
		&& bias_type_out == $past(sfr_wdata_in[2:1]) && com_phase_out == 0
		&& !frame_polarity_out)
		else $error("control write not applied");
	a_volt_write: assert property (sfr_wr_in && fc |=>
		lcd_drive_voltage_out == $past(sfr_wdata_in))
		else $error("drive voltage write lost");
	a_volt_read: assert property (sfr_rd_in && fc |=>
		sfr_rdata_out == $past(lcd_drive_voltage_out))
		else $error("drive voltage read wrong");
	a_sfr_miss: assert property (sfr_rd_in && !fc && sfr_addr_in != 8'hFD |=>
		sfr_rdata_out == 0)
		else $error("unmapped read not zero");
	a_ram_miss: assert property (ram_rd_in && !hit |=> ram_rdata_out == 0)
		else $error("display memory miss not zero");
	a_phase_hold: assert property (!watch_timer_en_in && $past(!watch_timer_en_in)
		&& !sfr_wr_in |=> $stable(com_phase_out) && $stable(frame_polarity_out))
		else $error("scan moved with watch timer off");
	a_phase_step: assert property ($changed(com_phase_out) && !$past(ctrl_wr) |->
		com_phase_out == 3'($past(com_phase_out) + 3'h1) || com_phase_out == 0)
		else $error("common skipped");
	a_wrap_pol: assert property ($changed(com_phase_out) && com_phase_out == 0
		&& !$past(ctrl_wr) |-> $changed(frame_polarity_out))
		else $error("wrap without inversion");
	c_ctrl: cover property (ctrl_wr);
	c_pol: cover property ($rose(frame_polarity_out));
	c_ram: cover property (ram_rd_in && hit);
endmodule
bind segment_lcd_driver segment_lcd_driver_props i_props (.core_clk_in, .rst_b_in,
	.watch_timer_en_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
	.ram_addr_in, .ram_rd_in, .ram_rdata_out, .pin_level_out, .display_on_out,
	.bias_type_out, .lcd_drive_voltage_out, .com_phase_out, .frame_polarity_out);

// *** test/lcd_panel_model.sv ***
`timescale 1ns/1ps
module lcd_panel_model #(parameter COM_PIN = 0, parameter BIAS = 2) (
	input wire [71:0] pins_in,
	output wire [23:0] lit_out
);
	// dot darkens when full bias spans it
	genvar p;
	for (p = 0; p < 24; p++) begin : g_dot
		wire [2:0] c = pins_in[3*COM_PIN +: 3];
		wire [2:0] s = pins_in[3*p +: 3];
		assign lit_out[p] = (c > s ? c - s : s - c) == BIAS;
	end
endmodule

// *** test/segment_lcd_driver_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
	$display("[FAIL] %s exp %h got %h", n, e, s); error_cnt++; end end
module segment_lcd_driver_test;
	reg clk = 0, rst_b = 0, wclk = 0, wen = 1;
	reg [7:0] sa = 0, sd = 0, rd8 = 0, q;
	reg sw = 0, sr = 0, rw = 0, bw = 0, bv = 0, rr = 0;
	reg [11:0] ra = 0;
	reg [2:0] bs = 0;
	reg [11:0] duty_exp [4] = '{12'h24C, 12'h24B, 12'h44B, 12'h40A};
	wire [7:0] srd, rrd, vo;
	wire [71:0] pl;
	wire [23:0] lit;
	wire [1:0] bt;
	wire [2:0] ph;
	wire on, pol;
	int error_cnt = 0, n_compared = 0, i;
	always #50 clk = ~clk;
	always #170 wclk = ~wclk;
	segment_lcd_driver i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .watch_clock_in(wclk),
		.watch_timer_en_in(wen), .sfr_addr_in(sa), .sfr_wr_in(sw), .sfr_rd_in(sr),
		.sfr_wdata_in(sd), .sfr_rdata_out(srd), .ram_addr_in(ra), .ram_wr_in(rw),
		.ram_bit_wr_in(bw), .ram_bit_sel_in(bs), .ram_bit_val_in(bv), .ram_rd_in(rr),
		.ram_wdata_in(rd8), .ram_rdata_out(rrd), .pin_level_out(pl), .display_on_out(on),
		.bias_type_out(bt), .lcd_drive_voltage_out(vo), .com_phase_out(ph),
		.frame_polarity_out(pol));
	lcd_panel_model #(.COM_PIN(0), .BIAS(2)) i_panel (.pins_in(pl), .lit_out(lit));
	task sfr(input bit w, input [7:0] ad, input [7:0] d);
		@(posedge clk);
		sa <= ad;
		sd <= d;
		sw <= w;
		sr <= !w;
		@(posedge clk);
		sw <= 0;
		sr <= 0;
		@(negedge clk);
		q = srd;
	endtask
	// k: 0 read, 1 byte write, 2 bit write (d[2:0] index, d[3] value)
	task ram(input [1:0] k, input [11:0] ad, input [7:0] d);
		@(posedge clk);
		ra <= ad;
		rd8 <= d;
		bs <= d[2:0];
		bv <= d[3];
		rw <= k == 1;
		bw <= k == 2;
		rr <= k == 0;
		@(posedge clk);
		{rw, bw, rr} <= 3'h0;
		@(negedge clk);
		q = rrd;
	endtask
	task settle;
		@(posedge clk);
		@(negedge clk);
	endtask
	task waitph(input [2:0] e);
		for (i = 0; i < 400 && ph !== e; i++)
			@(negedge clk);
		if (ph !== e) begin
			error_cnt++;
			tally_and_finish;
		end
		settle;
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		sfr(0, 8'hFC, 0);
		`CHK("volt_rst", 8'h00, q)
		sfr(0, 8'hFD, 0);
		`CHK("ctrl_rst", 8'h00, q)
		`CHK("pins_off", 72'h0, pl)
		sfr(1, 8'hFC, 8'hA5);
		sfr(0, 8'hFC, 0);
		`CHK("volt", 8'hA5, q)
		`CHK("drive_v", 8'hA5, vo)
		sfr(1, 8'hFD, 8'h02);
		repeat (10000) @(posedge clk);
		sfr(0, 8'hFD, 0);
		`CHK("ctrl", 8'h02, q)
		`CHK("bias_type", 2'h1, bt)
		sfr(1, 8'h10, 8'hFF);
		sfr(0, 8'h10, 0);
		`CHK("sfr_miss", 8'h00, q)
		$display("test regs done");
		ram(1, 12'h830, 8'h01);
		ram(1, 12'h831, 8'h02);
		ram(1, 12'h845, 8'h5A);
		ram(1, 12'h846, 8'h77);
		ram(2, 12'h836, 8'h0B);
		ram(0, 12'h845, 0);
		`CHK("ram_last", 8'h5A, q)
		ram(0, 12'h846, 0);
		`CHK("ram_miss", 8'h00, q)
		ram(0, 12'h836, 0);
		`CHK("ram_bit", 8'h08, q)
		$display("test ram done");
		for (int d = 0; d < 4; d++) begin
			sfr(1, 8'hFD, {2'b11, d[2:0], 3'b001});
			settle;
			`CHK("duty_pins", duty_exp[d], pl[11:0])
		end
		`CHK("lit_sel", 2'b01, lit[3:2])
		waitph(1);
		`CHK("phase1", 12'h091, pl[11:0])
		waitph(0);
		`CHK("wrap_pol", 1'b1, pol)
		`CHK("pol1_pins", 12'h088, pl[11:0])
		`CHK("lit_inv", 2'b01, lit[3:2])
		@(posedge clk);
		wen <= 0;
		repeat (300) @(posedge clk);
		@(negedge clk);
		`CHK("frozen", 3'h0, ph)
		`CHK("frozen_pol", 1'b1, pol)
		@(posedge clk);
		wen <= 1;
		waitph(1);
		sfr(1, 8'hFD, 8'hD9);
		`CHK("restart_ph", 3'h0, ph)
		`CHK("restart_pol", 1'b0, pol)
		sfr(1, 8'hFD, 8'hD8);
		settle;
		`CHK("off_pins", 72'h0, pl)
		`CHK("off_flag", 1'b0, on)
		$display("test lcd done");
		tally_and_finish;
	end
endmodule
